/* verilog/gpio_pin_port_pkg.sv */
package gpio_pin_port_pkg;

    // ==========================================================
    // Register map
    // ==========================================================
    localparam int PORT_WIDTH = 8;
    localparam int ADDR_WIDTH = 5;
    localparam logic [4:0] OFS_DIRECTION = 5'h00;
    localparam logic [4:0] OFS_DIRECTION_SET = 5'h01;
    localparam logic [4:0] OFS_DIRECTION_CLEAR = 5'h02;
    localparam logic [4:0] OFS_DIRECTION_TOGGLE = 5'h03;
    localparam logic [4:0] OFS_DRIVE = 5'h04;
    localparam logic [4:0] OFS_DRIVE_SET = 5'h05;
    localparam logic [4:0] OFS_DRIVE_CLEAR = 5'h06;
    localparam logic [4:0] OFS_DRIVE_TOGGLE = 5'h07;
    localparam logic [4:0] OFS_INPUT = 5'h08;
    localparam logic [4:0] OFS_FLAGS = 5'h09;
    localparam logic [4:0] OFS_PIN_CONFIG = 5'h10;
    // Mirror register indices.
    localparam logic [1:0] MIR_DIRECTION = 2'h0;
    localparam logic [1:0] MIR_DRIVE = 2'h1;
    localparam logic [1:0] MIR_INPUT = 2'h2;
    localparam logic [1:0] MIR_FLAGS = 2'h3;

    // ==========================================================
    // Pin configuration fields
    // ==========================================================
    localparam int CFG_INVERT_BIT = 7;
    localparam int CFG_PULL_UP_BIT = 3;
    localparam logic [7:0] CFG_RESET = 8'h00;
    localparam logic [7:0] CFG_WRITE_MASK = 8'h8f;
    localparam logic [7:0] BYTE_ZERO = 8'h00;
    // Cycles after a detection during which a synchronous pin ignores new events.
    localparam logic [1:0] DEAD_CYCLES = 2'h3;

    typedef enum logic [2:0] {
        SENSE_INTDISABLE = 3'b000,
        SENSE_BOTH_EDGES = 3'b001,
        SENSE_RISING = 3'b010,
        SENSE_FALLING = 3'b011,
        SENSE_INPUT_DISABLE = 3'b100,
        SENSE_LEVEL_LOW = 3'b101
    } sense_select_t;

    typedef struct packed {
        logic invertEnable;
        logic pullUpEnable;
        logic [2:0] senseSelect;
    } pin_config_t;

    typedef struct packed {
        logic write;
        logic read;
        logic [4:0] addr;
        logic [7:0] wdata;
    } reg_req_t;

    typedef struct packed {
        logic write;
        logic read;
        logic [1:0] addr;
        logic [7:0] wdata;
    } mirror_req_t;

endpackage : gpio_pin_port_pkg

/* verilog/pin_sense.sv */
`timescale 1ns/1ps
`default_nettype none
module pin_sense
    import gpio_pin_port_pkg::*;
#(
    parameter bit FULL_ASYNC = 1'b0
) (
    input wire logic sys_clk,
    input wire logic arst_n,
    input wire logic padIn,
    input wire logic invertEnable,
    input wire logic [2:0] senseSelect,
    output logic levelQ,
    output logic detect,
    output logic wakeRequest
);

    // ==========================================================
    // Synchroniser
    // ==========================================================
    logic senseNet;
    logic syncA_q;
    logic syncB_q;
    logic prev_q;
    logic [2:0] selPrev_q;
    logic [1:0] dead_q;
    logic hit;
    logic inputOn;

    assign senseNet = padIn ^ invertEnable;
    assign inputOn = (senseSelect != SENSE_INPUT_DISABLE);

    // Synchroniser holds still while the input is disabled to save power.
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            syncA_q <= 1'b0;
            syncB_q <= 1'b0;
        end else if (inputOn) begin
            syncA_q <= senseNet;
            syncB_q <= syncA_q;
        end
    end

    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            prev_q <= 1'b0;
            selPrev_q <= SENSE_INTDISABLE;
        end else begin
            prev_q <= syncB_q;
            selPrev_q <= senseSelect;
        end
    end

    // ==========================================================
    // Sense condition
    // ==========================================================
    always_comb begin
        hit = 1'b0;
        unique case (senseSelect)
            SENSE_BOTH_EDGES: hit = syncB_q ^ prev_q;
            SENSE_RISING: hit = syncB_q & ~prev_q;
            SENSE_FALLING: hit = ~syncB_q & prev_q;
            SENSE_LEVEL_LOW: hit = ~syncB_q;
            default: hit = 1'b0;
        endcase
    end

    // A detection is dropped in the cycle the setting changes.
    assign detect = hit && (selPrev_q == senseSelect) && (FULL_ASYNC || dead_q == 2'h0);

    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            dead_q <= 2'h0;
        end else if (detect && !FULL_ASYNC) begin
            dead_q <= DEAD_CYCLES;
        end else if (dead_q != 2'h0) begin
            dead_q <= dead_q - 2'h1;
        end
    end

    // Unclocked wake path; partly asynchronous pins only wake on both edges or level.
    always_comb begin
        wakeRequest = 1'b0;
        if (senseSelect == SENSE_LEVEL_LOW) begin
            wakeRequest = ~senseNet;
        end else if (senseSelect == SENSE_BOTH_EDGES || (FULL_ASYNC &&
                     (senseSelect == SENSE_RISING || senseSelect == SENSE_FALLING))) begin
            wakeRequest = senseNet ^ syncB_q;
        end
    end

    assign levelQ = syncB_q;

endmodule : pin_sense
`default_nettype wire

/* verilog/gpio_pin_port.sv */
`timescale 1ns/1ps
`default_nettype none
module gpio_pin_port
    import gpio_pin_port_pkg::*;
#(
    parameter int WIDTH = PORT_WIDTH,
    parameter logic [7:0] FULL_ASYNC_MASK = 8'h04
) (
    input wire logic sys_clk,
    input wire logic arst_n,
    input wire reg_req_t regReq,
    output logic [7:0] regRdata,
    input wire mirror_req_t mirrorReq,
    output logic [7:0] mirrorRdata,
    input wire logic [WIDTH-1:0] padIn,
    output logic [WIDTH-1:0] padOut,
    output logic [WIDTH-1:0] padOe,
    output logic [WIDTH-1:0] padPullUp,
    output logic [WIDTH-1:0] padSync,
    output logic portIrq,
    output logic wakeRequest
);

    // ==========================================================
    // Write decode
    // ==========================================================
    logic [WIDTH-1:0] direction_q;
    logic [WIDTH-1:0] drive_q;
    logic [WIDTH-1:0] flags_q;
    logic [7:0] config_q [WIDTH];
    logic [WIDTH-1:0] levels;
    logic [WIDTH-1:0] detects;
    logic [WIDTH-1:0] wakes;
    logic [WIDTH-1:0] invertVec;
    logic [WIDTH-1:0] wdata;
    logic [WIDTH-1:0] mdata;
    logic [7:0] rdata_d;
    logic [7:0] mrdata_d;

    function automatic logic hitReg(input reg_req_t r, input logic [4:0] ofs);
        hitReg = r.write && (r.addr == ofs);
    endfunction : hitReg

    function automatic logic hitMir(input mirror_req_t r, input logic [1:0] ofs);
        hitMir = r.write && (r.addr == ofs);
    endfunction : hitMir

    function automatic logic [7:0] pad8(input logic [WIDTH-1:0] v);
        pad8 = BYTE_ZERO;
        pad8[WIDTH-1:0] = v;
    endfunction : pad8

    assign wdata = regReq.wdata[WIDTH-1:0];
    assign mdata = mirrorReq.wdata[WIDTH-1:0];

    // ==========================================================
    // Direction
    // ==========================================================
    // Main bus write applies first, then the mirror write, so with both in one cycle the mirror value wins.
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            direction_q <= '0;
        end else begin
            logic [WIDTH-1:0] nx;
            nx = direction_q;
            if (hitReg(regReq, OFS_DIRECTION)) nx = wdata;
            if (hitReg(regReq, OFS_DIRECTION_SET)) nx = nx | wdata;
            if (hitReg(regReq, OFS_DIRECTION_CLEAR)) nx = nx & ~wdata;
            if (hitReg(regReq, OFS_DIRECTION_TOGGLE)) nx = nx ^ wdata;
            if (hitMir(mirrorReq, MIR_DIRECTION)) nx = mdata;
            direction_q <= nx;
        end
    end

    // ==========================================================
    // Drive value
    // ==========================================================
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            drive_q <= '0;
        end else begin
            logic [WIDTH-1:0] nx;
            nx = drive_q;
            if (hitReg(regReq, OFS_DRIVE)) nx = wdata;
            if (hitReg(regReq, OFS_DRIVE_SET)) nx = nx | wdata;
            if (hitReg(regReq, OFS_DRIVE_CLEAR)) nx = nx & ~wdata;
            if (hitReg(regReq, OFS_DRIVE_TOGGLE) || hitReg(regReq, OFS_INPUT)) begin
                nx = nx ^ wdata;
            end
            if (hitMir(mirrorReq, MIR_DRIVE)) nx = mdata;
            if (hitMir(mirrorReq, MIR_INPUT)) nx = nx ^ mdata;
            drive_q <= nx;
        end
    end

    // ==========================================================
    // Pin configuration
    // ==========================================================
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            for (int i = 0; i < WIDTH; i++) begin
                config_q[i] <= CFG_RESET;
            end
        end else begin
            for (int i = 0; i < WIDTH; i++) begin
                if (hitReg(regReq, OFS_PIN_CONFIG + 5'(i))) begin
                    config_q[i] <= regReq.wdata & CFG_WRITE_MASK;
                end
            end
        end
    end

    // ==========================================================
    // Flags
    // ==========================================================
    // A new detection wins over a clear in the same cycle.
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            flags_q <= '0;
        end else begin
            logic [WIDTH-1:0] clr;
            clr = '0;
            if (hitReg(regReq, OFS_FLAGS)) clr = clr | wdata;
            if (hitMir(mirrorReq, MIR_FLAGS)) clr = clr | mdata;
            flags_q <= (flags_q & ~clr) | detects;
        end
    end

    // ==========================================================
    // Per-pin sensing
    // ==========================================================
    for (genvar g = 0; g < WIDTH; g++) begin : gPin
        assign invertVec[g] = config_q[g][CFG_INVERT_BIT];
        pin_sense #(
            .FULL_ASYNC(FULL_ASYNC_MASK[g])
        ) uSense (
            .sys_clk(sys_clk),
            .arst_n(arst_n),
            .padIn(padIn[g]),
            .invertEnable(config_q[g][CFG_INVERT_BIT]),
            .senseSelect(config_q[g][2:0]),
            .levelQ(levels[g]),
            .detect(detects[g]),
            .wakeRequest(wakes[g])
        );
        assign padPullUp[g] = config_q[g][CFG_PULL_UP_BIT];
    end

    // Output enable follows direction straight from its register.
    assign padOe = direction_q;
    assign padOut = drive_q ^ invertVec;
    assign padSync = levels;
    // Flags are set only by enabled sense settings, so any flag means a request.
    assign portIrq = |flags_q;
    assign wakeRequest = |wakes;

    // ==========================================================
    // Read data
    // ==========================================================
    always_comb begin
        rdata_d = BYTE_ZERO;
        unique case (regReq.addr)
            OFS_DIRECTION, OFS_DIRECTION_SET, OFS_DIRECTION_CLEAR, OFS_DIRECTION_TOGGLE:
                rdata_d = pad8(direction_q);
            OFS_DRIVE, OFS_DRIVE_SET, OFS_DRIVE_CLEAR, OFS_DRIVE_TOGGLE:
                rdata_d = pad8(drive_q);
            OFS_INPUT: rdata_d = pad8(levels);
            OFS_FLAGS: rdata_d = pad8(flags_q);
            default: begin
                for (int i = 0; i < WIDTH; i++) begin
                    if (regReq.addr == OFS_PIN_CONFIG + 5'(i)) rdata_d = config_q[i];
                end
            end
        endcase
    end

    always_comb begin
        mrdata_d = BYTE_ZERO;
        unique case (mirrorReq.addr)
            MIR_DIRECTION: mrdata_d = pad8(direction_q);
            MIR_DRIVE: mrdata_d = pad8(drive_q);
            MIR_INPUT: mrdata_d = pad8(levels);
            MIR_FLAGS: mrdata_d = pad8(flags_q);
        endcase
    end

    // Read data is registered: it appears the cycle after the read strobe.
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            regRdata <= BYTE_ZERO;
            mirrorRdata <= BYTE_ZERO;
        end else begin
            if (regReq.read) regRdata <= rdata_d;
            if (mirrorReq.read) mirrorRdata <= mrdata_d;
        end
    end

endmodule : gpio_pin_port
`default_nettype wire

/* verif/gpio_pin_port_sva.sv */
`timescale 1ns/1ps
`default_nettype none
module gpio_pin_port_sva
    import gpio_pin_port_pkg::*;
(
    input wire logic sys_clk,
    input wire logic arst_n,
    input wire reg_req_t regReq,
    input wire logic [7:0] regRdata,
    input wire mirror_req_t mirrorReq,
    input wire logic [7:0] padOut,
    input wire logic [7:0] padOe,
    input wire logic [7:0] padPullUp,
    input wire logic [7:0] padSync,
    input wire logic portIrq
);
    // ==========================================================
    // Register effects seen at the pads, the read data and the request line
    // ==========================================================
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!arst_n);
    logic w;
    logic a_is_flags;
    // A same-cycle mirror write lands after the main one, so it is kept out.
    assign w = regReq.write && !mirrorReq.write;
    assign a_is_flags = (regReq.write && regReq.addr == OFS_FLAGS) || (mirrorReq.write && mirrorReq.addr == MIR_FLAGS);
    property p_reset_idle;
        $rose(arst_n) |-> padOe == 8'h00 && padOut == 8'h00;
    endproperty
    a_reset_idle: assert property (p_reset_idle) else $error("pads not idle after reset");
    property p_dir_write;
        w && regReq.addr == OFS_DIRECTION |=> padOe == $past(regReq.wdata);
    endproperty
    a_dir_write: assert property (p_dir_write) else $error("direction write lost");
    property p_dir_set;
        w && regReq.addr == OFS_DIRECTION_SET |=> padOe == ($past(padOe) | $past(regReq.wdata));
    endproperty
    a_dir_set: assert property (p_dir_set) else $error("direction set wrong");
    property p_dir_clear;
        w && regReq.addr == OFS_DIRECTION_CLEAR |=> padOe == ($past(padOe) & ~$past(regReq.wdata));
    endproperty
    a_dir_clear: assert property (p_dir_clear) else $error("direction clear wrong");
    property p_dir_toggle;
        w && regReq.addr == OFS_DIRECTION_TOGGLE |=> padOe == ($past(padOe) ^ $past(regReq.wdata));
    endproperty
    a_dir_toggle: assert property (p_dir_toggle) else $error("direction toggle wrong");
    property p_drive_toggle;
        w && (regReq.addr == OFS_DRIVE_TOGGLE || regReq.addr == OFS_INPUT) |=> padOut == ($past(padOut) ^ $past(regReq.wdata));
    endproperty
    a_drive_toggle: assert property (p_drive_toggle) else $error("drive toggle wrong");
    property p_mirror_dir;
        mirrorReq.write && mirrorReq.addr == MIR_DIRECTION && !regReq.write |=> padOe == $past(mirrorReq.wdata);
    endproperty
    a_mirror_dir: assert property (p_mirror_dir) else $error("mirror direction write lost");
    property p_pull_up;
        w && regReq.addr[4:3] == 2'b10 |=> padPullUp[$past(regReq.addr[2:0])] == $past(regReq.wdata[3]);
    endproperty
    a_pull_up: assert property (p_pull_up) else $error("pull-up not applied");
    property p_read_input;
        regReq.read && regReq.addr == OFS_INPUT |=> regRdata == $past(padSync);
    endproperty
    a_read_input: assert property (p_read_input) else $error("input read wrong");
    property p_irq_hold;
        portIrq && !a_is_flags |=> portIrq;
    endproperty
    a_irq_hold: assert property (p_irq_hold) else $error("request dropped with flag set");
endmodule : gpio_pin_port_sva
bind gpio_pin_port gpio_pin_port_sva i_gpio_pin_port_sva (.sys_clk(sys_clk), .arst_n(arst_n), .regReq(regReq),
    .regRdata(regRdata), .mirrorReq(mirrorReq), .padOut(padOut), .padOe(padOe), .padPullUp(padPullUp),
    .padSync(padSync), .portIrq(portIrq));
`default_nettype wire

/* verif/pad_partner.sv */
`timescale 1ns/1ps
`default_nettype none
module pad_partner (
    input wire logic sys_clk,
    input wire logic [7:0] padOut,
    input wire logic [7:0] padOe,
    input wire logic [7:0] padPullUp,
    input wire logic [7:0] extDrive,
    input wire logic [7:0] extLevel,
    output logic [7:0] padIn
);
    // A floating pad without pull-up wanders every cycle so that no undriven, unpulled read looks stable.
    logic [7:0] floatQ = 8'h55;
    always_ff @(posedge sys_clk) begin
        floatQ <= ~floatQ;
    end
    always_comb begin
        for (int i = 0; i < 8; i++) begin
            if (padOe[i]) begin
                padIn[i] = padOut[i];
            end else if (extDrive[i]) begin
                padIn[i] = extLevel[i];
            end else begin
                padIn[i] = padPullUp[i] | floatQ[i];
            end
        end
    end
endmodule : pad_partner
`default_nettype wire

/* verif/gpio_pin_port_tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
module gpio_pin_port_tb_top import gpio_pin_port_pkg::*;;
    logic sys_clk = 1'b0;
    logic arst_n = 1'b0;
    reg_req_t regReq = '0;
    mirror_req_t mirrorReq = '0;
    logic [7:0] regRdata, mirrorRdata, padIn, padOut, padOe, padPullUp, padSync, rdv;
    logic portIrq, wakeRequest;
    logic [7:0] extDrive = 8'h03;
    logic [7:0] extLevel = 8'h01;
    int mismatches = 0;
    int n_tests = 0;
    // Each entry is address, write data and the expected pad vector.
    logic [20:0] tbl [9] = '{21'h00a5a5, 21'h010aaf, 21'h02218e, 21'h03ff71, 21'h043c3c,
        21'h05c1fd, 21'h060df0, 21'h0711e1, 21'h0803e2};
    gpio_pin_port i_gpio_pin_port (.sys_clk(sys_clk), .arst_n(arst_n), .regReq(regReq), .regRdata(regRdata),
        .mirrorReq(mirrorReq), .mirrorRdata(mirrorRdata), .padIn(padIn), .padOut(padOut), .padOe(padOe),
        .padPullUp(padPullUp), .padSync(padSync), .portIrq(portIrq), .wakeRequest(wakeRequest));
    pad_partner i_pad_partner (.sys_clk(sys_clk), .padOut(padOut), .padOe(padOe), .padPullUp(padPullUp),
        .extDrive(extDrive), .extLevel(extLevel), .padIn(padIn));
    initial begin
        forever #5 sys_clk = ~sys_clk;
    end
    // ==========================================================
    // Access tasks
    // ==========================================================
    task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
        n_tests++;
        if (g !== e) begin
            mismatches++;
            $display("unexpected %s expected %h seen %h", nm, e, g);
        end
    endtask : chk
    task automatic acc(input bit mir, input bit wr, input logic [4:0] a, input logic [7:0] d);
        @(negedge sys_clk);
        if (mir) mirrorReq <= '{wr, !wr, a[1:0], d};
        else regReq <= '{wr, !wr, a, d};
        @(negedge sys_clk);
        regReq <= '0;
        mirrorReq <= '0;
        rdv = mir ? mirrorRdata : regRdata;
    endtask : acc
    task automatic close_out();
        $display("checks %0d mismatches %0d", n_tests, mismatches);
        if (mismatches == 0 && n_tests > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : close_out
    initial begin
        #200000;
        mismatches++;
        close_out();
    end
    // ==========================================================
    // Scenarios
    // ==========================================================
    initial begin
        repeat (4) @(negedge sys_clk);
        arst_n = 1'b1;
        chk("oe", 8'h00, padOe);
        acc(0, 0, OFS_DIRECTION, 8'h00);
        chk("dir", 8'h00, rdv);
        foreach (tbl[i]) begin
            acc(0, 1, tbl[i][20:16], tbl[i][15:8]);
            chk("pads", tbl[i][7:0], tbl[i][20:16] < 5'h04 ? padOe : padOut);
        end
        acc(0, 0, OFS_DIRECTION, 8'h00);
        chk("dir", 8'h71, rdv);
        acc(1, 1, MIR_DIRECTION, 8'h00);
        chk("oe", 8'h00, padOe);
        acc(1, 1, MIR_DRIVE, 8'h00);
        chk("out", 8'h00, padOut);
        acc(0, 1, OFS_PIN_CONFIG + 5'h01, 8'h88);
        chk("pull", 8'h02, padPullUp);
        chk("out", 8'h02, padOut);
        acc(0, 1, OFS_PIN_CONFIG + 5'h03, 8'h70);
        acc(0, 0, OFS_PIN_CONFIG + 5'h03, 8'h00);
        chk("cfg3", 8'h00, rdv);
        acc(0, 0, OFS_PIN_CONFIG + 5'h01, 8'h00);
        chk("cfg1", 8'h88, rdv);
        repeat (4) @(negedge sys_clk);
        acc(0, 0, OFS_INPUT, 8'h00);
        chk("in", 8'h03, rdv & 8'h03);
        acc(1, 0, MIR_INPUT, 8'h00);
        chk("vin", 8'h03, rdv & 8'h03);
        for (int s = 0; s < 6; s++) begin
            acc(0, 1, OFS_PIN_CONFIG, {5'h00, s[2:0]});
            repeat (4) @(negedge sys_clk);
            acc(0, 1, OFS_FLAGS, 8'hff);
            extLevel[0] = 1'b0;
            repeat (4) @(negedge sys_clk);
            acc(0, 1, OFS_FLAGS, 8'hfe);
            acc(0, 0, OFS_FLAGS, 8'h00);
            chk("fall", {7'h00, s == 1 || s == 3 || s == 5}, rdv);
            chk("irq", {7'h00, s == 1 || s == 3 || s == 5}, {7'h00, portIrq});
            acc(1, 1, MIR_FLAGS, 8'h01);
            extLevel[0] = 1'b1;
            repeat (4) @(negedge sys_clk);
            acc(0, 0, OFS_FLAGS, 8'h00);
            chk("rise", {7'h00, s == 1 || s == 2 || s == 5}, rdv);
            acc(0, 1, OFS_FLAGS, 8'hff);
            @(negedge sys_clk);
            chk("irq", 8'h00, {7'h00, portIrq});
        end
        chk("nowake", 8'h00, {7'h00, wakeRequest});
        // Pin 0 is left on low-level sense, so a low pad must raise the unclocked wake line.
        extLevel[0] = 1'b0;
        #1;
        chk("wake", 8'h01, {7'h00, wakeRequest});
        close_out();
    end
endmodule : gpio_pin_port_tb_top
`default_nettype wire
